// [design/acs_map.vh]
// register map, field positions and timing constants for the conversion sequencer
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
// register addresses (word index on the plain port)
`define ACS_ADDR_MODE 3'h0
`define ACS_ADDR_RESULT 3'h1
`define ACS_ADDR_PINSEL 3'h2
`define ACS_ADDR_STATUS 3'h3
`define ACS_ADDR_MASK 3'h4
`define ACS_ADDR_TRIGCFG 3'h5
// reset values
`define ACS_MODE_RST 8'h01
`define ACS_ZERO8 8'h00
// mode register fields
`define ACS_RUN_BIT 7
`define ACS_HWTRG_BIT 6
`define ACS_TSEL_HI_BIT 5
`define ACS_TSEL_LO_BIT 4
`define ACS_CH_HI 3
`define ACS_CH_LO 1
`define ACS_SPEED_BIT 0
// status / mask fields
`define ACS_ST_DONE 0
`define ACS_ST_BADTIME 1
// trigger config: bit 0 = 1 rising edge, 0 falling edge
`define ACS_TRG_EDGE_BIT 0
// conversion time codes {time_hi,time_lo,speed} and their clock counts
`define ACS_TC_160 3'h1
`define ACS_TC_80 3'h3
`define ACS_TC_100 3'h4
`define ACS_TC_200 3'h5
`define ACS_CYC_80 8'h50
`define ACS_CYC_100 8'h64
`define ACS_CYC_160 8'ha0
`define ACS_CYC_200 8'hc8
// successive approximation: first bit index and first tap at half reference
`define ACS_MSB 3'h7
`define ACS_TAP_HALF 8'h80
`define ACS_ONE8 8'h01
`endif

// [design/acs_sar_core.v]
// successive-approximation engine: one bit decision per step, msb first
`timescale 1ns/1ps
`include "acs_map.vh"
module acs_sar_core (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // control
  input wire start,
  input wire abort,
  input wire step,
  // comparator answer for the current tap
  input wire cmp_ge,
  // results
  output reg [7:0] tap_q,
  output reg busy_q,
  output reg done_q,
  output reg [7:0] code_q
);
  reg [2:0] bit_q;
  wire [7:0] bit_mask;
  wire [7:0] kept;

  assign bit_mask = `ACS_ONE8 << bit_q;
  // keep the trial bit when input is at or above the tap
  assign kept = cmp_ge ? tap_q : (tap_q & ~bit_mask); // R18

  // bit walk; an abort wins over a pending step so a rewrite never leaks a code
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bit_q <= 3'h0;
      tap_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      code_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      if (abort) begin
        busy_q <= 1'b0;
        tap_q <= 8'h00;
      end else if (start) begin
        busy_q <= 1'b1;
        bit_q <= `ACS_MSB;
        tap_q <= `ACS_TAP_HALF; // first tap at half reference
      end else if (busy_q && step) begin
        if (bit_q == 3'h0) begin
          code_q <= kept; // R18
          done_q <= 1'b1;
          busy_q <= 1'b0;
          tap_q <= 8'h00;
        end else begin
          bit_q <= bit_q - 3'h1;
          tap_q <= kept | (bit_mask >> 1); // R18
        end
      end
    end
  end
endmodule // acs_sar_core

// [design/acs_sequencer.v]
// conversion sequencer: mode register, start control, result and interrupt logic
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "acs_map.vh"
// Notes on behaviour
// R1: code is input over reference times 256, rounded to nearest integer.
// R2: conversions start from the external trigger or from a mode write.
// R3: finished code loads the result register and raises the done flag together.
// R4: hardware mode with run set waits, then converts the selected channel on trigger.
// R5: hardware mode does one conversion per trigger, then waits for a new one.
// R6: hardware mode run-set write mid conversion aborts and returns to waiting.
// R7: a write with run cleared halts any conversion at once.
// R8: software mode with run set starts converting the selected channel immediately.
// R9: software mode restarts after each completion until the next mode write.
// R10: software mode run-set write mid conversion aborts and restarts with new settings.
// R11: all logic runs on the system clock and stops when it stops.
// R12: mode writes never touch the done flag; software clears it.
// R13: a completion landing just before a rewrite still updates result and flag.
// R14: software clears the done flag before resuming stopped conversions.
// R15: software avoids reading the shared port during conversion.
// R16: mode register resets to 01h with run, trigger, time, channel, speed fields.
// R17: time and speed bits pick 80, 100, 160 or 200 clocks; others prohibited. The 100 setting gives 8 steps of 12, so 96 clocks.
// R18: bits resolved msb to lsb, kept when input at or above tap.
// R19: trigger taken on its configured edge as a single-cycle pulse.
module acs_sequencer (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // external trigger, taken as synchronous
  input wire external_trigger_input,
  // analog front end
  input wire cmp_ge,
  output reg [7:0] tap_code,
  output reg [2:0] mux_channel,
  output reg [7:0] analog_pin_select,
  output reg sample_hold,
  // interrupt and status
  output reg conversion_done_irq,
  output reg conv_busy
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_CONV = 2'h2;

  reg rst_meta_q;
  reg rst_n;
  reg [7:0] converter_mode_reg;
  reg [7:0] conversion_result_reg;
  reg [7:0] analog_pin_select_reg;
  reg [7:0] mask_q;
  reg [7:0] trig_cfg_q;
  reg [1:0] status_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg trig_prev_q;
  reg [7:0] cyc_cnt_q;
  reg [7:0] step_len;
  reg time_ok;
  reg sar_start;
  reg sar_abort;
  wire mode_wr;
  wire trig_pulse;
  wire step;
  wire sar_busy;
  wire sar_done;
  wire [7:0] sar_code;
  wire [7:0] sar_tap;
  wire [2:0] time_code;
  wire run_bit;
  wire hw_bit;
  wire [7:0] mode_next;

  // reset released through two flops; assertion stays asynchronous
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  assign mode_wr = reg_wr && (reg_addr == `ACS_ADDR_MODE);
  assign mode_next = mode_wr ? reg_wdata : converter_mode_reg;
  assign run_bit = mode_next[`ACS_RUN_BIT];
  assign hw_bit = mode_next[`ACS_HWTRG_BIT];
  assign time_code = {mode_next[`ACS_TSEL_HI_BIT], mode_next[`ACS_TSEL_LO_BIT], mode_next[`ACS_SPEED_BIT]};

  // conversion time per setting; prohibited codes stall, and flag an error when written with run set
  always @* begin
    time_ok = 1'b1;
    case (time_code)
      `ACS_TC_80: step_len = `ACS_CYC_80; // R17
      `ACS_TC_100: step_len = `ACS_CYC_100; // R17
      `ACS_TC_160: step_len = `ACS_CYC_160; // R17
      `ACS_TC_200: step_len = `ACS_CYC_200; // R17
      default: begin
        step_len = `ACS_CYC_200;
        time_ok = 1'b0;
      end
    endcase
  end

  // edge detect on the trigger pin, polarity chosen by software
  assign trig_pulse = trig_cfg_q[`ACS_TRG_EDGE_BIT] ? (external_trigger_input & ~trig_prev_q) :
                      (~external_trigger_input & trig_prev_q); // R19

  // total time split over 8 bit decisions, 1/8 of the count each rounded down (96 clocks for the 100 setting)
  assign step = (cyc_cnt_q == {3'h0, step_len[7:3]} - 8'h01);

  // start, wait and abort decisions
  always @* begin
    state_d = state_q;
    sar_start = 1'b0;
    sar_abort = 1'b0;
    if (mode_wr) begin
      sar_abort = 1'b1; // R6 R10
      if (!run_bit || !time_ok) begin
        state_d = ST_IDLE; // R7
      end else if (hw_bit) begin
        state_d = ST_WAIT; // R4 R6
      end else begin
        state_d = ST_CONV; // R8 R10
        sar_start = 1'b1; // R2
      end
    end else begin
      case (state_q)
        ST_IDLE: state_d = ST_IDLE;
        ST_WAIT: begin
          if (trig_pulse) begin
            state_d = ST_CONV; // R4
            sar_start = 1'b1; // R2
          end
        end
        ST_CONV: begin
          if (sar_done) begin
            if (hw_bit) begin
              state_d = ST_WAIT; // R5
            end else begin
              sar_start = 1'b1; // R9
            end
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  // sequencer state and step timer, all on the system clock
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cyc_cnt_q <= `ACS_ZERO8;
      trig_prev_q <= 1'b0;
    end else begin
      state_q <= state_d; // R11
      trig_prev_q <= external_trigger_input;
      if (sar_start || sar_abort || step) begin
        cyc_cnt_q <= `ACS_ZERO8;
      end else begin
        cyc_cnt_q <= cyc_cnt_q + 8'h01;
      end
    end
  end

  acs_sar_core u_sar (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(sar_start),
    .abort(sar_abort && !sar_start),
    .step(step),
    .cmp_ge(cmp_ge),
    .tap_q(sar_tap),
    .busy_q(sar_busy),
    .done_q(sar_done),
    .code_q(sar_code)
  );

  // registers, result latch and sticky status; hardware set beats software clear
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      converter_mode_reg <= `ACS_MODE_RST; // R16
      conversion_result_reg <= `ACS_ZERO8;
      analog_pin_select_reg <= `ACS_ZERO8;
      mask_q <= `ACS_ZERO8;
      trig_cfg_q <= `ACS_ONE8;
      status_q <= 2'h0;
    end else begin
      if (mode_wr) begin
        converter_mode_reg <= reg_wdata; // R16
      end
      if (reg_wr && reg_addr == `ACS_ADDR_PINSEL) begin
        analog_pin_select_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == `ACS_ADDR_MASK) begin
        mask_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == `ACS_ADDR_TRIGCFG) begin
        trig_cfg_q <= reg_wdata;
      end
      // a completion in the rewrite cycle is still kept; mode writes never clear
      if (sar_done) begin
        conversion_result_reg <= sar_code; // R1 R3 R13
      end
      status_q[`ACS_ST_DONE] <= sar_done | (status_q[`ACS_ST_DONE] &
        ~(reg_wr && reg_addr == `ACS_ADDR_STATUS && reg_wdata[`ACS_ST_DONE])); // R3 R12 R13 R14
      status_q[`ACS_ST_BADTIME] <= (mode_wr && run_bit && !time_ok) | (status_q[`ACS_ST_BADTIME] &
        ~(reg_wr && reg_addr == `ACS_ADDR_STATUS && reg_wdata[`ACS_ST_BADTIME]));
    end
  end

  // read port and registered outputs
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `ACS_ZERO8;
      tap_code <= `ACS_ZERO8;
      mux_channel <= 3'h0;
      analog_pin_select <= `ACS_ZERO8;
      sample_hold <= 1'b0;
      conversion_done_irq <= 1'b0;
      conv_busy <= 1'b0;
    end else begin
      if (reg_rd) begin
        case (reg_addr)
          `ACS_ADDR_MODE: reg_rdata <= converter_mode_reg;
          `ACS_ADDR_RESULT: reg_rdata <= conversion_result_reg;
          `ACS_ADDR_PINSEL: reg_rdata <= analog_pin_select_reg;
          `ACS_ADDR_STATUS: reg_rdata <= {6'h00, status_q};
          `ACS_ADDR_MASK: reg_rdata <= mask_q;
          `ACS_ADDR_TRIGCFG: reg_rdata <= trig_cfg_q;
          default: reg_rdata <= `ACS_ZERO8;
        endcase
      end else begin
        reg_rdata <= `ACS_ZERO8;
      end
      tap_code <= sar_tap; // R18
      mux_channel <= converter_mode_reg[`ACS_CH_HI:`ACS_CH_LO]; // R4 R8
      analog_pin_select <= analog_pin_select_reg;
      sample_hold <= sar_busy;
      conversion_done_irq <= |(status_q & mask_q[1:0]);
      conv_busy <= sar_busy; // R15
    end
  end
endmodule // acs_sequencer

// [tb/acs_afe_model.sv]
// analog front end model: one input level per channel against the tap
`timescale 1ns/1ps
module acs_afe_model (
  // from the sequencer
  input wire [7:0] tap_code,
  input wire [2:0] mux_channel,
  // comparator answer
  output wire cmp_ge
);
  // levels are in result steps, so rounding is exact
  logic [7:0] level [8];
  // input at or above the tap keeps the trial bit
  assign cmp_ge = level[mux_channel] >= tap_code;
endmodule // acs_afe_model

// [tb/acs_sequencer_props.sv]
// port assertions for the conversion sequencer
`timescale 1ns/1ps
`include "acs_map.vh"
module acs_sequencer_props (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // trigger and front end
  input wire external_trigger_input,
  input wire cmp_ge,
  input wire [7:0] tap_code,
  input wire [2:0] mux_channel,
  input wire [7:0] analog_pin_select,
  input wire sample_hold,
  // status
  input wire conversion_done_irq,
  input wire conv_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // mode write decode and its time code
  wire mode_wr = reg_wr && reg_addr == `ACS_ADDR_MODE;
  wire [2:0] tc = {reg_wdata[5:4], reg_wdata[0]};
  wire tc_ok = tc == 3'h1 || tc == 3'h3 || tc == 3'h4 || tc == 3'h5;
  // written value shows two edges after the write; no local variables needed
  property p_mux;
    mode_wr ##1 !mode_wr |-> ##1 mux_channel == $past(reg_wdata[3:1], 2);
  endproperty
  property p_pin;
    (reg_wr && reg_addr == `ACS_ADDR_PINSEL) ##1 !reg_wr |-> ##1 analog_pin_select == $past(reg_wdata, 2);
  endproperty
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata == 8'h00) else $error("unmapped read");
  a_hold_busy: assert property (sample_hold == (tap_code != 8'h00)) else $error("hold and tap disagree");
  a_mux_follow: assert property (p_mux) else $error("channel not applied");
  a_pin_follow: assert property (p_pin) else $error("pin select not applied");
  a_stop_now: assert property (mode_wr && !reg_wdata[7] ##1 !mode_wr |=> !conv_busy) else $error("no halt");
  a_sw_start: assert property (mode_wr && reg_wdata[7:6] == 2'b10 && tc_ok |-> ##[1:3] conv_busy)
    else $error("no software start");
  a_hw_wait: assert property (($stable(external_trigger_input) [*4]) ##0
    (mode_wr && reg_wdata[7:6] == 2'b11) ##1 ($stable(external_trigger_input) [*2]) |-> !conv_busy)
    else $error("no wait");
  // a clear or mask write just before the rewrite may drop the level on its own
  a_irq_keep: assert property (conversion_done_irq && mode_wr &&
    !$past(reg_wr && (reg_addr == `ACS_ADDR_STATUS || reg_addr == `ACS_ADDR_MASK)) |=> conversion_done_irq)
    else $error("flag lost");
  a_tap_msb: assert property ($rose(conv_busy) |-> ##[0:2] tap_code == 8'h80) else $error("msb not first");
  c_done: cover property ($rose(conversion_done_irq));
  c_hw: cover property (mode_wr && reg_wdata[7:6] == 2'b11);
  c_stop: cover property ($fell(conv_busy));
endmodule // acs_sequencer_props

// [tb/tb_top.sv]
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`include "acs_map.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %0t mismatch", $time); end end
module tb_top;
  logic clk_sys, nrst, reg_wr, reg_rd, external_trigger_input;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, d;
  wire [7:0] reg_rdata, tap_code, analog_pin_select;
  wire [2:0] mux_channel;
  wire cmp_ge, sample_hold, conversion_done_irq, conv_busy;
  int fail_count, comparisons, i, n;
  logic [7:0] tcm [4] = '{8'h01, 8'h11, 8'h20, 8'h21};
  int tcy [4] = '{160, 80, 100, 200};
  acs_sequencer dut_u (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .external_trigger_input, .cmp_ge, .tap_code, .mux_channel, .analog_pin_select, .sample_hold,
    .conversion_done_irq, .conv_busy);
  acs_afe_model afe_u (.tap_code, .mux_channel, .cmp_ge);
  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // gap cycle first, so a strobe is never set and cleared in one step
  task automatic wr(input [2:0] a, input [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input [2:0] a, output [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // bounded wait for the interrupt, n counts cycles; looks only after an edge so a stale level is not taken
  task automatic wirq;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (conversion_done_irq !== 1'b1 && n < 400);
    if (n >= 400) begin
      fail_count++;
      $display("[FAIL] %0t no interrupt", $time);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog well past the expected run
  initial begin
    cyc(20000);
    fail_count++;
    final_report;
  end
  // main sequence
  initial begin
    clk_sys = 0; nrst = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0; external_trigger_input = 0;
    for (i = 0; i < 8; i++) afe_u.level[i] = 8'h21 + 8'h13 * i[7:0];
    cyc(16);
    nrst <= 1'b1;
    cyc(3);
    rd(`ACS_ADDR_MODE, d); `CHK(d, `ACS_MODE_RST)
    rd(`ACS_ADDR_PINSEL, d); `CHK(d, 8'h00)
    rd(`ACS_ADDR_TRIGCFG, d); `CHK(d, 8'h01)
    rd(3'h7, d); `CHK(d, 8'h00)
    $display("reset test done");
    wr(`ACS_ADDR_MASK, 8'h03);
    wr(`ACS_ADDR_PINSEL, 8'hff);
    wr(`ACS_ADDR_MODE, 8'h87);
    wirq; rd(`ACS_ADDR_RESULT, d); `CHK(d, afe_u.level[3])
    wr(`ACS_ADDR_STATUS, 8'h01);
    wirq; `CHK(n > 100 && n < 200, 1'b1)
    wr(`ACS_ADDR_MODE, 8'h05);
    rd(`ACS_ADDR_STATUS, d); `CHK(d[0], 1'b1)
    `CHK(conv_busy, 1'b0)
    wr(`ACS_ADDR_STATUS, 8'h01);
    wr(`ACS_ADDR_MODE, 8'h87);
    cyc(50);
    wr(`ACS_ADDR_MODE, 8'h8b);
    wirq; `CHK(n > 150, 1'b1)
    rd(`ACS_ADDR_RESULT, d); `CHK(d, afe_u.level[5])
    $display("software start test done");
    for (i = 0; i < 4; i++) begin
      wr(`ACS_ADDR_MODE, 8'h00);
      wr(`ACS_ADDR_STATUS, 8'h01);
      wr(`ACS_ADDR_MODE, 8'h80 | tcm[i]);
      wirq; `CHK(n >= tcy[i] - 8 && n <= tcy[i] + 8, 1'b1)
    end
    wr(`ACS_ADDR_MODE, 8'h90);
    rd(`ACS_ADDR_STATUS, d); `CHK(d[1], 1'b1)
    `CHK(conv_busy, 1'b0)
    wr(`ACS_ADDR_MASK, 8'h00);
    cyc(2); #1 `CHK(conversion_done_irq, 1'b0)
    wr(`ACS_ADDR_MASK, 8'h02);
    cyc(2); #1 `CHK(conversion_done_irq, 1'b1)
    wr(`ACS_ADDR_STATUS, 8'h03);
    cyc(2); #1 `CHK(conversion_done_irq, 1'b0)
    $display("time and interrupt test done");
    wr(`ACS_ADDR_MASK, 8'h01);
    wr(`ACS_ADDR_MODE, 8'hcd);
    cyc(300); #1 `CHK(conv_busy, 1'b0)
    `CHK(conversion_done_irq, 1'b0)
    cyc(1);
    external_trigger_input <= 1'b1;
    wirq; rd(`ACS_ADDR_RESULT, d); `CHK(d, afe_u.level[6])
    cyc(300); #1 `CHK(conv_busy, 1'b0)
    wr(`ACS_ADDR_STATUS, 8'h01);
    external_trigger_input <= 1'b0;
    cyc(5);
    external_trigger_input <= 1'b1;
    cyc(40);
    wr(`ACS_ADDR_MODE, 8'hcd);
    cyc(3); #1 `CHK(conv_busy, 1'b0)
    cyc(1);
    external_trigger_input <= 1'b0;
    cyc(5);
    external_trigger_input <= 1'b1;
    wirq; `CHK(n > 150, 1'b1)
    // falling edge chosen: the fall starts a conversion, a rise must not
    wr(`ACS_ADDR_TRIGCFG, 8'h00);
    wr(`ACS_ADDR_MODE, 8'hc3);
    wr(`ACS_ADDR_STATUS, 8'h01);
    external_trigger_input <= 1'b0;
    wirq; rd(`ACS_ADDR_RESULT, d); `CHK(d, afe_u.level[1])
    wr(`ACS_ADDR_STATUS, 8'h01);
    external_trigger_input <= 1'b1;
    cyc(300); #1 `CHK(conversion_done_irq, 1'b0)
    $display("hardware start test done");
    final_report;
  end
endmodule // tb_top
bind acs_sequencer acs_sequencer_props props_u (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .external_trigger_input, .cmp_ge, .tap_code, .mux_channel, .analog_pin_select, .sample_hold,
  .conversion_done_irq, .conv_busy);
